// >>> sim/dsil_src_model.sv
`timescale 1ns/100ps
// Parallel sample source, moves data on falling edges only
module dsil_src_model (
   input wire logic clk_i,
   output logic [11:0] data_o,
   output logic valid_o
);
   initial begin
      data_o = 12'h000;
      valid_o = 1'b0;
   end
   // One word per cycle, back to back
   task automatic send(input logic [11:0] code);
      @(negedge clk_i);
      data_o = code;
      valid_o = 1'b1;
   endtask
   // Released bus shows the inverse, never a stale word
   task automatic idle();
      @(negedge clk_i);
      valid_o = 1'b0;
      data_o = ~data_o;
   endtask
endmodule

// >>> sim/tb_dac_sample_input_latch.sv
`timescale 1ns/100ps
module tb_dac_sample_input_latch;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic sleep_i = 1'b0;
   logic [1:0] strap = 2'h0;
   logic [11:0] sample;
   logic valid, ready, term, awake;
   logic [1:0] mode;
   dsil_pkg::dsil_out_t cur;
   int errors = 0;
   int check_count = 0;
   initial begin
      // Single full-swing rail, as a single-ended clock source drives it
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   dsil_src_model src (.clk_i(sys_clk_i), .data_o(sample), .valid_o(valid));
   // Short wake count keeps the sleep scenario brief
   localparam int WAKE_SIM = 4;
   dsil_latch #(.WAKE_CYCLES(WAKE_SIM)) DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .sample_i(sample), .sample_valid_i(valid), .sample_ready_o(ready),
      .sleep_i(sleep_i), .clock_receiver_select_i(strap), .clk_mode_o(mode),
      .terminations_on_o(term), .awake_o(awake), .current_o(cur));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // True code and its complement as one word
   function automatic logic [23:0] pair(input logic [11:0] c);
      return {c, 12'hfff - c};
   endfunction
   // Each strap level, mode taken once after reset
   task automatic strap_modes();
      for (int i = 0; i < 4; i++) begin
         strap = i[1:0];
         rstn_i = 1'b0;
         repeat (2) @(negedge sys_clk_i);
         check(cur, pair(12'h000));
         rstn_i = 1'b1;
         repeat (2) @(negedge sys_clk_i);
         check({22'h0, mode}, (i == 0) ? 24'h0 : (i == 1) ? 24'h1 : 24'h2);
         check({23'h0, term}, {23'h0, i > 1});
      end
   endtask
   // Back-to-back stream; order and no loss checked, latency left free
   task automatic stream();
      logic [11:0] codes [6] = '{12'h123, 12'hfff, 12'h000, 12'h800, 12'h001, 12'h7ff};
      logic [23:0] seen [$];
      logic [23:0] last;
      last = cur;
      fork
         begin
            foreach (codes[k]) src.send(codes[k]);
            src.idle();
         end
         repeat (12) begin
            @(negedge sys_clk_i);
            check({23'h0, ready}, 24'h1);
            if (cur !== last) seen.push_back(cur);
            last = cur;
         end
      join
      check(24'(seen.size()), 24'h6);
      foreach (seen[k]) check(seen[k], pair(codes[k]));
   endtask
   // Sleep cuts current, a short wake falls back, a full wake restores the code
   task automatic sleep_wake();
      int n;
      @(negedge sys_clk_i);
      sleep_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      check({23'h0, awake}, 24'h0);
      check(cur, 24'h0);
      // Drop the request briefly, then raise it again mid-wake
      sleep_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      sleep_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      check({23'h0, awake}, 24'h0);
      check(cur, 24'h0);
      sleep_i = 1'b0;
      n = 0;
      while (awake !== 1'b1 && n < 20) begin
         @(negedge sys_clk_i);
         n++;
         if (awake !== 1'b1) begin
            check(cur, 24'h0);
         end
      end
      if (awake !== 1'b1) begin
         check({23'h0, awake}, 24'h1);
         finish_test();
      end else begin
         check(24'(n), 24'(WAKE_SIM + 1));
         @(negedge sys_clk_i);
         check(cur, pair(12'h7ff));
      end
   endtask
   initial begin
      strap_modes();
      stream();
      sleep_wake();
      finish_test();
   end
endmodule

// >>> verilog/dsil_latch.sv
`timescale 1ns/100ps
module dsil_latch #(
   parameter int WAKE_CYCLES = dsil_pkg::WAKE_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [11:0] sample_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic sleep_i,
   input wire logic [1:0] clock_receiver_select_i,
   output logic [1:0] clk_mode_o,
   output logic terminations_on_o,
   output logic awake_o,
   output dsil_pkg::dsil_out_t current_o
);
   localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYCLES - 1);

   // Whole state of the block, registered in one place
   typedef struct packed {
      // Two-slot sample buffer and its pointers
      logic [1:0][11:0] buf_data;
      logic [1:0] buf_full;
      logic wr_ptr;
      logic rd_ptr;
      // Held code and power sequencing
      logic [11:0] code;
      dsil_pkg::dsil_pwr_t pwr;
      logic [15:0] wake_cnt;
      // Clock receiver strap, taken once
      logic strap_taken;
      dsil_pkg::dsil_clk_mode_t mode;
      // Registered current pair
      dsil_pkg::dsil_out_t out;
   } dsil_state_t;

   dsil_state_t st;
   dsil_state_t next_st;

   // Strap decode; a floating pin reads as either upper code
   function automatic dsil_pkg::dsil_clk_mode_t strap_mode(input logic [1:0] s);
      case (s)
         dsil_pkg::DSIL_STRAP_GND: strap_mode = dsil_pkg::DSIL_CLK_SINGLE;
         dsil_pkg::DSIL_STRAP_SUPPLY: strap_mode = dsil_pkg::DSIL_CLK_DIFF;
         default: strap_mode = dsil_pkg::DSIL_CLK_TERM;
      endcase
   endfunction

   // Buffer handshake and run status
   logic push;
   logic pop;
   logic powered;

   // Buffer accepts while a slot is free; drain is the converter itself
   assign sample_ready_o = !st.buf_full[st.wr_ptr];
   assign push = sample_valid_i && sample_ready_o;
   assign pop = st.buf_full[st.rd_ptr];
   assign powered = (st.pwr == dsil_pkg::DSIL_RUN);

   // Next state: buffer first, then power state, and the output pair last,
   // built from the new code and new power state so that code and current
   // move on the same edge while running
   always_comb begin
      next_st = st;
      // Two-entry buffer so a brief stall loses nothing
      if (push) begin
         next_st.buf_data[st.wr_ptr] = sample_i;
         next_st.buf_full[st.wr_ptr] = 1'b1;
         next_st.wr_ptr = !st.wr_ptr;
      end
      // The converter takes a word on every edge one is waiting
      if (pop) begin
         next_st.code = st.buf_data[st.rd_ptr];
         next_st.buf_full[st.rd_ptr] = 1'b0;
         next_st.rd_ptr = !st.rd_ptr;
      end
      // Strap caught once after reset release, never under reset
      if (!st.strap_taken) begin
         next_st.mode = strap_mode(clock_receiver_select_i);
         next_st.strap_taken = 1'b1;
      end
      // Power state: off in one cycle, slow wake count
      case (st.pwr)
         // Running: a request cuts current at the next edge
         dsil_pkg::DSIL_RUN: begin
            if (sleep_i) begin
               next_st.pwr = dsil_pkg::DSIL_SLEEP;
            end
         end
         // Asleep: wake sequence starts once the request falls
         dsil_pkg::DSIL_SLEEP: begin
            if (!sleep_i) begin
               next_st.pwr = dsil_pkg::DSIL_WAKE;
               next_st.wake_cnt = 16'h0000;
            end
         end
         // Waking: a new request sends it straight back to sleep
         dsil_pkg::DSIL_WAKE: begin
            if (sleep_i) begin
               next_st.pwr = dsil_pkg::DSIL_SLEEP;
            end else if (st.wake_cnt >= WAKE_LAST) begin
               next_st.pwr = dsil_pkg::DSIL_RUN;
            end else begin
               next_st.wake_cnt = st.wake_cnt + 16'h0001;
            end
         end
         default: next_st.pwr = dsil_pkg::DSIL_RUN;
      endcase
      // Output pair from the held code; zero current while asleep
      if (next_st.pwr == dsil_pkg::DSIL_RUN) begin
         next_st.out.true_current_out = next_st.code;
         next_st.out.complement_current_out = dsil_pkg::CODE_MAX - next_st.code;
      end else begin
         next_st.out = '0;
      end
   end

   // Held code starts at zero, so outputs are defined before any capture
   // Reset branch loads constants only, no logic on the reset path
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
         st.code <= dsil_pkg::CODE_RST;
         st.out.complement_current_out <= dsil_pkg::CODE_MAX;
      end else begin
         st <= next_st;
      end
   end

   // Mode and current outputs taken straight from the flops, termination and awake flags decoded from them
   assign clk_mode_o = st.mode;
   assign terminations_on_o = (st.mode == dsil_pkg::DSIL_CLK_TERM);
   assign awake_o = powered;
   assign current_o = st.out;

   // Outputs always sum to full-scale code when awake
   a_out_complement: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      powered |-> (st.out.true_current_out + st.out.complement_current_out == 12'hfff))
      else $error("outputs not complementary");
   a_out_follows: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (pop && powered && !sleep_i) |=> (st.out.true_current_out == $past(st.buf_data[st.rd_ptr])))
      else $error("true output did not follow captured code");
   a_sleep_off: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      sleep_i |=> (st.out == '0))
      else $error("current not off after sleep");
   a_wake_delay: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (st.pwr == dsil_pkg::DSIL_SLEEP && !sleep_i) |=> !powered)
      else $error("woke too early");
   a_no_loss: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      push |=> (st.buf_full != 2'b00))
      else $error("accepted sample lost");
   a_hold_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !pop |=> $stable(st.code))
      else $error("code changed without capture");
   a_mode_fixed: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      st.strap_taken |=> $stable(st.mode))
      else $error("clock mode changed after strap");
   a_term_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (!st.strap_taken && clock_receiver_select_i[1])
      |=> (terminations_on_o && clk_mode_o == dsil_pkg::DSIL_CLK_TERM))
      else $error("termination flag wrong");
   a_strap_single: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (!st.strap_taken && clock_receiver_select_i == 2'h0)
      |=> (!terminations_on_o && clk_mode_o == dsil_pkg::DSIL_CLK_SINGLE))
      else $error("strap to ground not single-ended");
   a_strap_diff: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (!st.strap_taken && clock_receiver_select_i == 2'h1)
      |=> (!terminations_on_o && clk_mode_o == dsil_pkg::DSIL_CLK_DIFF))
      else $error("strap to supply not differential");
   a_mode_legal: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      clk_mode_o != 2'h3)
      else $error("unused clock mode code");

   // Buffer never backs up, since the converter drains every edge
   a_ready_free: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      sample_ready_o)
      else $error("buffer refused a sample");
   a_one_slot: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      st.buf_full != 2'h3)
      else $error("buffer holds two samples");
   a_drain_every: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (st.buf_full != 2'h0) |=> (st.code == $past(st.buf_data[st.rd_ptr])))
      else $error("waiting word not taken at next edge");
   a_capture_next: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (push && st.buf_full == 2'h0) |-> ##2 (st.code == $past(sample_i, 2)))
      else $error("taken sample not held two edges later");

   // Held code and output pair between captures
   a_code_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !st.strap_taken |-> (st.code == dsil_pkg::CODE_RST))
      else $error("held code not zero before first capture");
   a_true_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      powered |-> (st.out.true_current_out == st.code))
      else $error("true output differs from held code");
   a_out_stands: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (powered && !pop && !sleep_i) |=> $stable(st.out))
      else $error("output moved without a capture");

   // Power sequencing: off at once, back only after the full count
   a_asleep_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !powered |-> (st.out == '0))
      else $error("current flows while not running");
   a_wake_full: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(powered) |-> ($past(st.pwr) == dsil_pkg::DSIL_WAKE
         && $past(st.wake_cnt) == WAKE_LAST))
      else $error("woke before the full count");
   a_wake_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (st.pwr == dsil_pkg::DSIL_WAKE && !sleep_i && st.wake_cnt < WAKE_LAST)
      |=> (st.pwr == dsil_pkg::DSIL_WAKE))
      else $error("wake count cut short");
   a_wake_restart: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (st.pwr == dsil_pkg::DSIL_WAKE && sleep_i) |=> (st.pwr == dsil_pkg::DSIL_SLEEP))
      else $error("sleep during wake ignored");
endmodule

// >>> verilog/dsil_pkg.sv
package dsil_pkg;
   // Sample word layout
   localparam int SAMPLE_W = 12;
   localparam int SAMPLE_MSB_POS = 11;
   localparam int SAMPLE_LSB_POS = 0;
   localparam logic [11:0] CODE_MAX = 12'hfff;
   localparam logic [12:0] CODE_SPAN = 13'h1000;
   localparam logic [11:0] CODE_RST = 12'h000;

   // Clock rate and sleep timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int MAX_RATE_MSPS = 210;
   localparam int SLEEP_OFF_NS = 50;
   localparam int WAKE_US = 5;
   // Shortest time rounds down, at least one cycle
   localparam int SLEEP_OFF_CYC = (SLEEP_OFF_NS / CLK_PERIOD_NS) < 1 ? 1 :
      (SLEEP_OFF_NS / CLK_PERIOD_NS);
   localparam int WAKE_CYC = (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_W = 8;

   // Clock receiver modes
   typedef enum logic [1:0] {
      DSIL_CLK_SINGLE = 2'b00,
      DSIL_CLK_DIFF = 2'b01,
      DSIL_CLK_TERM = 2'b10
   } dsil_clk_mode_t;

   // Strap level seen on the mode pin
   typedef enum logic [1:0] {
      DSIL_STRAP_GND = 2'b00,
      DSIL_STRAP_SUPPLY = 2'b01,
      DSIL_STRAP_FLOAT = 2'b10
   } dsil_strap_t;

   typedef enum logic [1:0] {
      DSIL_RUN = 2'b00,
      DSIL_SLEEP = 2'b01,
      DSIL_WAKE = 2'b10
   } dsil_pwr_t;

   // Pair of output current codes
   typedef struct packed {
      logic [11:0] true_current_out;
      logic [11:0] complement_current_out;
   } dsil_out_t;
endpackage
